/* logic/misc_config_bank.v */
// system configuration register bank: tally, reference disable, levels
//
// Operation
// - 4-bit read/write watchdog tally, bits 3:0
// - power-on clears tally, watchdog reset keeps it
// - disable bit set kills reference function only
// - disable bit resets zero, function enabled
// - lock bit sticky, zero writes ignored
// - lock set makes levels and lock read-only
// - level bits 0..2, reset zero
// - level 1 means 1.8V, 0 means 3.3V
// - hardware sets levels after standby power-on
`timescale 1ns/1ps
`include "misc_config_map.vh"

module misc_config_bank (
	input wire clk,
	input wire rst,
	input wire wdt_reset_cause,
	input wire standby_por_done,
	input wire [`LEVEL_MSB:0] standby_rail_level,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output wire [31:0] rdata,
	output wire cpu_reference_voltage_pin_en,
	output wire [`LEVEL_MSB:0] rail_is_1v8,
	output wire level_lock
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	reg hit_tally;
	reg hit_refdis;
	reg hit_level;

	// unmapped addresses hit nothing
	always @*
	begin
		hit_tally = 1'h0;
		hit_refdis = 1'h0;
		hit_level = 1'h0;
		case (addr)
			`TALLY_OFS:
			begin
				hit_tally = 1'h1;
			end
			`REFDIS_OFS:
			begin
				hit_refdis = 1'h1;
			end
			`LEVEL_OFS:
			begin
				hit_level = 1'h1;
			end
			default:
			begin
				hit_tally = 1'h0;
				hit_refdis = 1'h0;
				hit_level = 1'h0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// write strobes
	// ------------------------------------------------------------
	reg wr_tally;
	reg wr_refdis;
	reg wr_level;

	// no strobe reaches a register while idle
	always @*
	begin
		wr_tally = 1'h0;
		wr_refdis = 1'h0;
		wr_level = 1'h0;
		if (wr)
		begin
			wr_tally = hit_tally;
			wr_refdis = hit_refdis;
			wr_level = hit_level;
		end
	end

	// ------------------------------------------------------------
	// read strobes
	// ------------------------------------------------------------
	reg rd_tally;
	reg rd_refdis;
	reg rd_level;

	always @*
	begin
		rd_tally = 1'h0;
		rd_refdis = 1'h0;
		rd_level = 1'h0;
		if (rd)
		begin
			rd_tally = hit_tally;
			rd_refdis = hit_refdis;
			rd_level = hit_level;
		end
	end

	// ------------------------------------------------------------
	// write data fields
	// ------------------------------------------------------------
	// positions outside the fields are ignored
	wire [`TALLY_MSB:0] wfield_tally;
	wire wfield_refdis;
	wire [`LEVEL_MSB:0] wfield_level;
	wire wfield_lock;

	assign wfield_tally = wdata[`TALLY_MSB:0];
	assign wfield_refdis = wdata[`REFDIS_BIT];
	assign wfield_level = wdata[`LEVEL_MSB:0];
	assign wfield_lock = wdata[`LOCK_BIT];

	// ------------------------------------------------------------
	// watchdog firing tally
	// ------------------------------------------------------------
	wire [`TALLY_MSB:0] tally;

	// survives a watchdog-caused reset
	fire_tally u_tally (
		.clk(clk),
		.rst(rst),
		.wdt_reset_cause(wdt_reset_cause),
		.wr_en(wr_tally),
		.wr_data(wfield_tally),
		.tally(tally)
	);

	// ------------------------------------------------------------
	// bank supply levels and lock
	// ------------------------------------------------------------
	wire [`LEVEL_MSB:0] level;
	wire lock;

	// hardware load still lands while locked
	supply_level_lock u_level (
		.clk(clk),
		.rst(rst),
		.hw_set(standby_por_done),
		.hw_level(standby_rail_level),
		.wr_en(wr_level),
		.wr_level(wfield_level),
		.wr_lock(wfield_lock),
		.level(level),
		.lock(lock)
	);

	// ------------------------------------------------------------
	// reference pin disable
	// ------------------------------------------------------------
	reg refdis_q;
	reg refdis_d;

	always @*
	begin
		refdis_d = refdis_q;
		if (wr_refdis)
		begin
			refdis_d = wfield_refdis;
		end
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			refdis_q <= `REFDIS_RST;
		end
		else
		begin
			refdis_q <= refdis_d;
		end
	end

	// ------------------------------------------------------------
	// reference function enable
	// ------------------------------------------------------------
	reg ref_en_q;
	reg ref_en_d;

	// inverse of the disable bit, kept in its own flop
	always @*
	begin
		ref_en_d = ~refdis_d;
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			ref_en_q <= ~`REFDIS_RST;
		end
		else
		begin
			ref_en_q <= ref_en_d;
		end
	end

	// ------------------------------------------------------------
	// tally read view
	// ------------------------------------------------------------
	reg [31:0] view_tally;

	always @*
	begin
		view_tally = 32'h0000_0000;
		view_tally[`TALLY_MSB:0] = tally;
	end

	// ------------------------------------------------------------
	// reference disable read view
	// ------------------------------------------------------------
	reg [31:0] view_refdis;

	always @*
	begin
		view_refdis = 32'h0000_0000;
		view_refdis[`REFDIS_BIT] = refdis_q;
	end

	// ------------------------------------------------------------
	// level read view
	// ------------------------------------------------------------
	reg [31:0] view_level;

	// lock bit rides beside the three levels
	always @*
	begin
		view_level = 32'h0000_0000;
		view_level[`LEVEL_MSB:0] = level;
		view_level[`LOCK_BIT] = lock;
	end

	// ------------------------------------------------------------
	// read source codes
	// ------------------------------------------------------------
	localparam [1:0] SEL_NONE = 2'h0;
	localparam [1:0] SEL_TALLY = 2'h1;
	localparam [1:0] SEL_REFDIS = 2'h2;
	localparam [1:0] SEL_LEVEL = 2'h3;

	// ------------------------------------------------------------
	// read source select
	// ------------------------------------------------------------
	reg [1:0] rsel;

	// idle cycles and unmapped reads pick nothing
	always @*
	begin
		rsel = SEL_NONE;
		if (rd_tally)
		begin
			rsel = SEL_TALLY;
		end
		else if (rd_refdis)
		begin
			rsel = SEL_REFDIS;
		end
		else if (rd_level)
		begin
			rsel = SEL_LEVEL;
		end
	end

	// ------------------------------------------------------------
	// read data mux
	// ------------------------------------------------------------
	reg [31:0] rdata_d;
	reg [31:0] rdata_q;

	always @*
	begin
		case (rsel)
			SEL_TALLY:
			begin
				rdata_d = view_tally;
			end
			SEL_REFDIS:
			begin
				rdata_d = view_refdis;
			end
			SEL_LEVEL:
			begin
				rdata_d = view_level;
			end
			default:
			begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// read data stands one cycle, then zero
	always @(posedge clk)
	begin
		if (rst)
		begin
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// read data output
	// ------------------------------------------------------------
	assign rdata = rdata_q;

	// ------------------------------------------------------------
	// reference function output
	// ------------------------------------------------------------
	assign cpu_reference_voltage_pin_en = ref_en_q;

	// ------------------------------------------------------------
	// level and lock outputs
	// ------------------------------------------------------------
	// one flop-backed bit per rail, 1 = 1.8V, 0 = 3.3V
	genvar rail;

	generate
		for (rail = 0; rail <= `LEVEL_MSB; rail = rail + 1)
		begin : g_rail
			assign rail_is_1v8[rail] = level[rail];
		end
	endgenerate

	assign level_lock = lock;

endmodule // misc_config_bank

/* shared/misc_config_map.vh */
// register offsets, field positions, reset values for the config bank
`ifndef MISC_CONFIG_MAP_VH
`define MISC_CONFIG_MAP_VH

`define TALLY_OFS 8'h28
`define REFDIS_OFS 8'h40
`define LEVEL_OFS 8'h64

`define TALLY_MSB 3
`define TALLY_RST 4'h0
`define REFDIS_BIT 0
`define REFDIS_RST 1'h0
`define LEVEL_MSB 2
`define LEVEL_RST 3'h0
`define LOCK_BIT 7
`define LOCK_RST 1'h0

`endif

/* logic/fire_tally.v */
// watchdog firing tally, kept across watchdog resets
`timescale 1ns/1ps
`include "misc_config_map.vh"

module fire_tally (
	input wire clk,
	input wire rst,
	input wire wdt_reset_cause,
	input wire wr_en,
	input wire [`TALLY_MSB:0] wr_data,
	output wire [`TALLY_MSB:0] tally
);

	reg [`TALLY_MSB:0] tally_q;
	reg [`TALLY_MSB:0] tally_d;

	always @*
	begin
		tally_d = tally_q;
		if (wr_en)
			tally_d = wr_data;
	end

	// power-on reset clears, watchdog-caused reset keeps
	always @(posedge clk)
	begin
		if (rst && !wdt_reset_cause)
			tally_q <= `TALLY_RST;
		else if (!rst)
			tally_q <= tally_d;
	end

	assign tally = tally_q;

endmodule // fire_tally

/* logic/supply_level_lock.v */
// bank supply level bits with sticky lock
`timescale 1ns/1ps
`include "misc_config_map.vh"

module supply_level_lock (
	input wire clk,
	input wire rst,
	input wire hw_set,
	input wire [`LEVEL_MSB:0] hw_level,
	input wire wr_en,
	input wire [`LEVEL_MSB:0] wr_level,
	input wire wr_lock,
	output wire [`LEVEL_MSB:0] level,
	output wire lock
);

	reg [`LEVEL_MSB:0] level_q;
	reg [`LEVEL_MSB:0] level_d;
	reg lock_q;
	reg lock_d;

	always @*
	begin
		level_d = level_q;
		lock_d = lock_q;
		if (hw_set)
			level_d = hw_level;
		if (wr_en && !lock_q)
		begin
			level_d = wr_level;
			lock_d = wr_lock;
		end
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			level_q <= `LEVEL_RST;
			lock_q <= `LOCK_RST;
		end
		else
		begin
			level_q <= level_d;
			lock_q <= lock_d;
		end
	end

	assign level = level_q;
	assign lock = lock_q;

endmodule // supply_level_lock

/* tb/misc_config_bank_assertions.sv */
// config bank checker
`timescale 1ns/1ps
module cfg_chk (
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	input wire [31:0] rdata,
	input wire [2:0] rail_is_1v8,
	input wire level_lock
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire lw = wr && addr == 8'h64;
	wire ul = lw && !level_lock;
	AST_STICK: assert property (level_lock |=> level_lock)
		else $error("stick");
	AST_SET: assert property (ul && wdata[7] |=> level_lock)
		else $error("set");
	AST_NOSET: assert property (ul && !wdata[7] |=> !level_lock)
		else $error("noset");
	AST_LVL: assert property (ul |=> rail_is_1v8 == $past(wdata[2:0]))
		else $error("lvl");
	AST_IDLE: assert property (!rd |=> rdata == 32'h0)
		else $error("idle");
	AST_TRES: assert property (rd && addr == 8'h28 |=> !rdata[31:4])
		else $error("tres");
	AST_RRES: assert property (rd && addr == 8'h40 |=> !rdata[31:1])
		else $error("rres");
	AST_LRD: assert property (rd && addr == 8'h64 |=>
		rdata == {24'h0, $past(level_lock), 4'h0, $past(rail_is_1v8)})
		else $error("lrd");
endmodule // cfg_chk
bind misc_config_bank cfg_chk u_chk (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.rail_is_1v8(rail_is_1v8), .level_lock(level_lock));

/* tb/misc_config_bank_tb.sv */
// config bank bench
`timescale 1ns/1ps
module misc_config_bank_tb;
	logic clk = 0, rst = 1, wc = 0, sp = 0, wr = 0, rd = 0, p = 0, re, lk;
	logic [2:0] sl = 0, lv;
	logic [7:0] a = 0;
	logic [31:0] d = 0, rdata, v, q[$];
	int err_count = 0, n_tests = 0;
	misc_config_bank dut (.clk(clk), .rst(rst), .wdt_reset_cause(wc),
		.standby_por_done(sp), .standby_rail_level(sl), .addr(a),
		.wdata(d), .wr(wr), .rd(rd), .rdata(rdata),
		.cpu_reference_voltage_pin_en(re), .rail_is_1v8(lv),
		.level_lock(lk));
	initial forever #50 clk = ~clk;
	task chk(input [31:0] g, e);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %0t %h %h", $time, g, e);
		end
	endtask
	task chk_pin(input [3:0] g, e);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %0t %h %h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("%0d tests %0d errors", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task w(input [7:0] x, input [31:0] y);
		a <= x;
		d <= y;
		wr <= 1;
		rd <= 0;
		@(posedge clk);
	endtask
	task r(input [7:0] x, input [31:0] e);
		a <= x;
		q.push_back(e);
		wr <= 0;
		rd <= 1;
		@(posedge clk);
	endtask
	task sr(input c);
		wc <= c;
		rd <= 0;
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		@(posedge clk);
	endtask
	always @(posedge clk)
	begin
		if (p)
			chk(rdata, q.pop_front());
		p <= rd;
	end
	initial
	begin
		repeat (1000) @(posedge clk);
		err_count++;
		report_and_stop;
	end
	initial
	begin
		v = $urandom(79052);
		v = $urandom;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk_pin(re, 1);
		r(8'h28, 0);
		r(8'h40, 0);
		r(8'h64, 0);
		$display("t1");
		w(8'h28, v);
		r(8'h28, v & 15);
		sr(1);
		r(8'h28, v & 15);
		w(8'h28, (v + 1) & 15);
		r(8'h28, (v + 1) & 15);
		sr(0);
		r(8'h28, 0);
		$display("t2");
		w(8'h40, v | 1);
		r(8'h40, 1);
		chk_pin(re, 0);
		w(8'h40, 0);
		w(8'h64, 5);
		chk_pin(re, 1);
		r(8'h64, 5);
		chk_pin(lv, 5);
		chk_pin(lk, 0);
		sl <= 3'h2;
		sp <= 1;
		rd <= 0;
		@(posedge clk);
		sp <= 0;
		r(8'h64, 2);
		w(8'h64, 0);
		r(8'h64, 0);
		w(8'h64, v | 8'h80);
		w(8'h64, 0);
		chk_pin(lk, 1);
		chk_pin(lv, v[2:0]);
		r(8'h64, v & 8'h87);
		sl <= v[5:3];
		sp <= 1;
		rd <= 0;
		@(posedge clk);
		sp <= 0;
		r(8'h64, 32'h80 | v[5:3]);
		r(8'h30, 0);
		$display("t3");
		rd <= 0;
		repeat (2) @(posedge clk);
		report_and_stop;
	end
endmodule // misc_config_bank_tb
